// >>> hdl/asr_clkdiv.sv
`timescale 1ns/1ps
module asr_clkdiv (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// Control
	input wire logic sys_run,
	input wire logic [2:0] clk_select,
	// Enables
	output logic instr_en,
	output logic tad_en
);
	logic [5:0] sys_cnt;
	logic [5:0] next_sys_cnt;
	logic [8:0] rc_cnt;
	logic [8:0] next_rc_cnt;
	logic rc_tick;
	logic [5:0] mask;

	// System rates stop while asleep; the RC source keeps running
	always_comb
	begin
		mask = asr_pkg::tad_mask(clk_select);
		rc_tick = rc_cnt == 9'(asr_pkg::RC_DIV_CYCLES - 1);
		next_rc_cnt = rc_tick ? 9'h000 : rc_cnt + 9'h001;
		next_sys_cnt = sys_run ? sys_cnt + 6'h01 : sys_cnt;
		instr_en = sys_run && sys_cnt[1:0] == 2'(asr_pkg::INSTR_CLKS - 1);
		if (asr_pkg::is_rc_clock(clk_select))
			tad_en = rc_tick;
		else
			tad_en = sys_run && (sys_cnt & mask) == mask;
	end

	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			sys_cnt <= 6'h00;
			rc_cnt <= 9'h000;
		end
		else
		begin
			sys_cnt <= next_sys_cnt;
			rc_cnt <= next_rc_cnt;
		end
	end
endmodule

// >>> hdl/asr_ctrl.sv
// The APB register port was chosen for this implementation.
`timescale 1ns/1ps
// What this block does
// (RULE_01) Conversion survives sleep only with the RC conversion clock.
// (RULE_02) With RC clock, start is held off one instruction cycle.
// (RULE_03) On completion go clears and the result registers load.
// (RULE_04) Completion in sleep with converter interrupt enabled wakes the device.
// (RULE_05) Completion in sleep without that enable powers down; on bit stays set.
// (RULE_06) Sleep with a non-RC clock aborts and powers down; on bit stays.
// (RULE_07) Reset restores control registers, powers down, aborts any conversion.
// (RULE_08) Reset leaves both result registers unchanged.
// (RULE_09) Left justify: high holds upper 8, low top 2; right: reversed.
// (RULE_10) Software waits the acquisition time after a channel change.
// (RULE_11) Go set while on starts; it stays set until results load.
// (RULE_12) Completion sets the flag; request needs converter, peripheral, global enables.
module asr_ctrl (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Processor side
	input wire logic sleep_active,
	output logic wake_req,
	output logic irq,
	// Analog conversion core
	output logic conv_power,
	output logic [1:0] channel_select,
	output logic reference_select,
	output logic [3:0] analog_pin_select,
	output logic [9:0] dac_code,
	input wire logic cmp_in
);
	// ****************************************
	// State
	// ****************************************
	asr_pkg::asr_state_e st;
	asr_pkg::asr_state_e next_st;
	logic [7:0] int_ctrl;
	logic [7:0] next_int_ctrl;
	logic [7:0] periph_en;
	logic [7:0] next_periph_en;
	logic [7:0] pin_clk_sel;
	logic [7:0] next_pin_clk_sel;
	logic conv_int_flag;
	logic next_conv_int_flag;
	logic justify;
	logic next_justify;
	logic next_ref;
	logic [1:0] next_chan;
	logic go;
	logic next_go;
	logic on;
	logic next_on;
	logic pwr_off;
	logic next_pwr_off;
	logic next_wake;
	logic [31:0] next_prdata;
	logic next_pslverr;
	logic [7:0] result_high;
	logic [7:0] next_result_high;
	logic [7:0] result_low;
	logic [7:0] next_result_low;
	logic [7:0] rd_byte;
	logic results_known;

	// Decode and event terms
	logic [9:0] idx;
	logic setup;
	logic wr;
	logic rc;
	logic wake_en;
	logic start_req;
	logic abort;
	logic sar_start;
	logic done;
	logic instr_en;
	logic tad_en;
	logic sar_busy;
	logic sar_done;
	logic [9:0] sar_result;

	function automatic logic wr_to(input logic [9:0] target);
		return wr && idx == target;
	endfunction

	// ****************************************
	// Bus decode
	// ****************************************
	// Zero wait states; read data and error are latched in the setup cycle
	assign pready = 1'b1;
	assign idx = paddr[11:2];
	assign setup = psel && !penable;
	assign wr = psel && penable && pwrite && !pslverr;

	// Outputs decoded combinationally from control flops
	assign analog_pin_select = pin_clk_sel[3:0];
	assign conv_power = on && !pwr_off; // [RULE_05] [RULE_06]
	assign irq = conv_int_flag && periph_en[asr_pkg::BIT_CONV_INT] &&
		int_ctrl[asr_pkg::BIT_PERIPH_INT_EN] && int_ctrl[asr_pkg::BIT_GLOBAL_INT_EN]; // [RULE_12]

	// Conversion events
	always_comb
	begin
		rc = asr_pkg::is_rc_clock(pin_clk_sel[6:4]);
		wake_en = periph_en[asr_pkg::BIT_CONV_INT] && int_ctrl[asr_pkg::BIT_PERIPH_INT_EN];
		start_req = wr_to(asr_pkg::IDX_CONV_CTRL) && pwdata[asr_pkg::BIT_GO] &&
			pwdata[asr_pkg::BIT_ON] && st == asr_pkg::st_idle && !sleep_active; // [RULE_11]
		// Sleep on a system-derived clock kills the conversion outright
		abort = st != asr_pkg::st_idle && ((sleep_active && !rc) ||
			(wr_to(asr_pkg::IDX_CONV_CTRL) &&
			!(pwdata[asr_pkg::BIT_GO] && pwdata[asr_pkg::BIT_ON]))); // [RULE_06] [RULE_01]
		// RC start waits for the next instruction edge so the sleep can land first
		sar_start = !abort && ((st == asr_pkg::st_idle && start_req && !rc) ||
			(st == asr_pkg::st_hold && (instr_en || sleep_active))); // [RULE_02]
		done = st == asr_pkg::st_conv && sar_done && !abort;
	end

	// ****************************************
	// Control next values
	// ****************************************
	always_comb
	begin
		next_st = st;
		case (st)
			asr_pkg::st_idle:
				if (start_req)
					next_st = rc ? asr_pkg::st_hold : asr_pkg::st_conv; // [RULE_02]
			asr_pkg::st_hold:
				if (abort)
					next_st = asr_pkg::st_idle;
				else if (sar_start)
					next_st = asr_pkg::st_conv;
			asr_pkg::st_conv:
				if (abort || sar_done)
					next_st = asr_pkg::st_idle;
			default: next_st = asr_pkg::st_idle;
		endcase

		next_int_ctrl = wr_to(asr_pkg::IDX_INT_CTRL) ? pwdata[7:0] : int_ctrl;
		next_periph_en = wr_to(asr_pkg::IDX_PERIPH_ENABLES) ? pwdata[7:0] : periph_en;
		next_pin_clk_sel = pin_clk_sel;
		if (wr_to(asr_pkg::IDX_PIN_CLK_SEL))
			next_pin_clk_sel = {1'b0, pwdata[6:0]};

		next_justify = justify;
		next_ref = reference_select;
		next_chan = channel_select;
		next_on = on;
		if (wr_to(asr_pkg::IDX_CONV_CTRL))
		begin
			next_justify = pwdata[asr_pkg::BIT_JUSTIFY];
			next_ref = pwdata[asr_pkg::BIT_REF_SEL];
			next_chan = pwdata[asr_pkg::BIT_CHAN_LO +: 2];
			next_on = pwdata[asr_pkg::BIT_ON];
		end

		// Go is owned by hardware once the conversion is under way
		next_go = go;
		if (start_req)
			next_go = 1'b1; // [RULE_11]
		if (done || abort)
			next_go = 1'b0; // [RULE_03]

		// Flag: a completion beats a clear in the same cycle
		next_conv_int_flag = conv_int_flag;
		if (wr_to(asr_pkg::IDX_PERIPH_FLAGS) && pwdata[asr_pkg::BIT_CONV_INT])
			next_conv_int_flag = 1'b0;
		if (done)
			next_conv_int_flag = 1'b1; // [RULE_12]

		// Power-down in sleep never touches the on bit itself
		next_pwr_off = pwr_off;
		if (!sleep_active)
			next_pwr_off = 1'b0;
		if (sleep_active && !rc)
			next_pwr_off = 1'b1; // [RULE_06]
		if (done && sleep_active && !wake_en)
			next_pwr_off = 1'b1; // [RULE_05]
		next_wake = done && sleep_active && wake_en; // [RULE_04]

		// Read data captured during setup
		case (idx)
			asr_pkg::IDX_INT_CTRL: rd_byte = int_ctrl;
			asr_pkg::IDX_PERIPH_FLAGS: rd_byte = 8'(conv_int_flag) << asr_pkg::BIT_CONV_INT;
			asr_pkg::IDX_RESULT_HIGH: rd_byte = result_high;
			asr_pkg::IDX_CONV_CTRL: rd_byte = {justify, reference_select, 2'h0, channel_select, go, on};
			asr_pkg::IDX_PERIPH_ENABLES: rd_byte = periph_en;
			asr_pkg::IDX_RESULT_LOW: rd_byte = result_low;
			asr_pkg::IDX_PIN_CLK_SEL: rd_byte = pin_clk_sel;
			default: rd_byte = 8'h00;
		endcase
		next_prdata = prdata;
		next_pslverr = pslverr;
		if (setup)
		begin
			next_pslverr = !asr_pkg::is_mapped(idx) || paddr[1:0] != 2'h0;
			next_prdata = (pwrite || next_pslverr) ? 32'h0000_0000 : {24'h00_0000, rd_byte};
		end
	end

	// Synchronous reset brings back every control value
	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			st <= asr_pkg::st_idle; // [RULE_07]
			int_ctrl <= asr_pkg::RST_INT_CTRL;
			periph_en <= asr_pkg::RST_PERIPH_ENABLES;
			pin_clk_sel <= asr_pkg::RST_PIN_CLK_SEL;
			conv_int_flag <= 1'b0;
			justify <= 1'b0;
			reference_select <= 1'b0;
			channel_select <= 2'h0;
			go <= 1'b0;
			on <= 1'b0;
			pwr_off <= 1'b0;
			wake_req <= 1'b0;
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end
		else
		begin
			st <= next_st;
			int_ctrl <= next_int_ctrl;
			periph_en <= next_periph_en;
			pin_clk_sel <= next_pin_clk_sel;
			conv_int_flag <= next_conv_int_flag;
			justify <= next_justify;
			reference_select <= next_ref;
			channel_select <= next_chan;
			go <= next_go;
			on <= next_on;
			pwr_off <= next_pwr_off;
			wake_req <= next_wake;
			prdata <= next_prdata;
			pslverr <= next_pslverr;
		end
	end

	// ****************************************
	// Result registers
	// ****************************************
	// Completion overrides a software write in the same cycle
	always_comb
	begin
		next_result_high = wr_to(asr_pkg::IDX_RESULT_HIGH) ? pwdata[7:0] : result_high;
		next_result_low = wr_to(asr_pkg::IDX_RESULT_LOW) ? pwdata[7:0] : result_low;
		if (done)
		begin
			if (justify)
			begin
				next_result_high = {6'h00, sar_result[9:8]}; // [RULE_09]
				next_result_low = sar_result[7:0];
			end
			else
			begin
				next_result_high = sar_result[9:2]; // [RULE_09]
				next_result_low = {sar_result[1:0], 6'h00};
			end
		end
	end

	// No reset: results survive any device reset
	always_ff @(posedge ref_clk)
	begin
		if (!reset)
		begin
			result_high <= next_result_high; // [RULE_08] [RULE_03]
			result_low <= next_result_low;
			// Arms the reset check only once both results hold a converted value
			if (done)
				results_known <= 1'b1;
		end
	end

	// ****************************************
	// Rate generation and converter core
	// ****************************************
	asr_clkdiv u_clkdiv (
		.ref_clk(ref_clk),
		.reset(reset),
		.sys_run(!sleep_active),
		.clk_select(pin_clk_sel[6:4]),
		.instr_en(instr_en),
		.tad_en(tad_en)
	);

	asr_sar u_sar (
		.ref_clk(ref_clk),
		.reset(reset),
		.start(sar_start),
		.abort(abort),
		.tad_en(tad_en),
		.cmp_in(cmp_in),
		.busy(sar_busy),
		.done(sar_done),
		.dac_code(dac_code),
		.result(sar_result)
	);

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);

	sequence s_rc_request;
		st == asr_pkg::st_idle && start_req && rc;
	endsequence

	sequence s_held_start;
		!sar_start ##1 st == asr_pkg::st_hold ##[0:4] (sar_start || st == asr_pkg::st_idle);
	endsequence

	chk_rc_holdoff_start: assert property (s_rc_request |-> s_held_start) // [RULE_02]
		else $error("RC start not held off one instruction cycle");
	chk_rc_sleep_runs: assert property ( // [RULE_01]
		st == asr_pkg::st_conv && sleep_active && rc && !sar_done && !wr |=>
		st == asr_pkg::st_conv && (sar_busy || sar_done))
		else $error("RC conversion stopped by sleep");
	chk_sleep_abort: assert property ( // [RULE_06]
		st != asr_pkg::st_idle && sleep_active && !rc && !wr |=> st == asr_pkg::st_idle && !go && on == $past(on)
		##0 !conv_power)
		else $error("Sleep on system clock did not abort and power down");
	chk_done_loads: assert property ( // [RULE_03]
		done && !justify |=> !go && result_high == $past(sar_result[9:2]) && result_low[7:6] == $past(sar_result[1:0]))
		else $error("Completion did not clear go or load left result");
	chk_right_justify: assert property ( // [RULE_09]
		done && justify |=> result_high == {6'h00, $past(sar_result[9:8])} && result_low == $past(sar_result[7:0]))
		else $error("Right-justified result misplaced");
	chk_wake_on_done: assert property ( // [RULE_04]
		done && sleep_active && wake_en |=> wake_req ##1 !wake_req)
		else $error("No single wake pulse on completion in sleep");
	chk_sleep_power_off: assert property ( // [RULE_05]
		done && sleep_active && !wake_en && !wr |=> !conv_power && on && !wake_req)
		else $error("Converter not powered down with on bit kept");
	chk_reset_state: assert property (@(posedge ref_clk) disable iff (1'b0) // [RULE_07]
		reset |=> st == asr_pkg::st_idle && !go && !on && !conv_power && !sar_busy &&
		pin_clk_sel == asr_pkg::RST_PIN_CLK_SEL && int_ctrl == asr_pkg::RST_INT_CTRL)
		else $error("Reset did not restore control state");
	chk_reset_keeps_result: assert property (@(posedge ref_clk) disable iff (1'b0) // [RULE_08]
		reset && results_known |=> result_high == $past(result_high) && result_low == $past(result_low))
		else $error("Reset changed the result registers");
	chk_go_held: assert property ( // [RULE_11]
		go && st == asr_pkg::st_conv && !sar_done && !abort |=> go)
		else $error("Go dropped before result load");
	chk_flag_and_irq: assert property ( // [RULE_12]
		done |=> conv_int_flag ##0 irq == (periph_en[asr_pkg::BIT_CONV_INT] &&
		int_ctrl[asr_pkg::BIT_PERIPH_INT_EN] && int_ctrl[asr_pkg::BIT_GLOBAL_INT_EN]))
		else $error("Completion flag or interrupt gating wrong");
endmodule

// >>> hdl/asr_pkg.sv
package asr_pkg;
	// ****************************************
	// Register indices, byte address is index * 4
	// ****************************************
	localparam logic [9:0] IDX_INT_CTRL = 10'h00b;
	localparam logic [9:0] IDX_PERIPH_FLAGS = 10'h00c;
	localparam logic [9:0] IDX_RESULT_HIGH = 10'h01e;
	localparam logic [9:0] IDX_CONV_CTRL = 10'h01f;
	localparam logic [9:0] IDX_PERIPH_ENABLES = 10'h08c;
	localparam logic [9:0] IDX_RESULT_LOW = 10'h09e;
	localparam logic [9:0] IDX_PIN_CLK_SEL = 10'h09f;

	// Reset values
	localparam logic [7:0] RST_INT_CTRL = 8'h00;
	localparam logic [7:0] RST_PERIPH_ENABLES = 8'h00;
	localparam logic [7:0] RST_PIN_CLK_SEL = 8'h0f;

	// Field positions
	localparam int BIT_GLOBAL_INT_EN = 7;
	localparam int BIT_PERIPH_INT_EN = 6;
	localparam int BIT_CONV_INT = 6;
	localparam int BIT_JUSTIFY = 7;
	localparam int BIT_REF_SEL = 6;
	localparam int BIT_CHAN_LO = 2;
	localparam int BIT_GO = 1;
	localparam int BIT_ON = 0;
	localparam int BIT_CLK_SEL_LO = 4;

	// Timing: 250 MHz system clock, RC converter clock at most 500 kHz
	localparam int CLK_PERIOD_NS = 4;
	localparam int RC_PERIOD_NS = 2000;
	localparam int RC_DIV_CYCLES = (RC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int INSTR_CLKS = 4;
	localparam int RESULT_BITS = 10;

	typedef enum logic [1:0] {st_idle, st_hold, st_conv} asr_state_e;

	// Conversion clock select codes with either low pattern 11 pick the RC source
	function automatic logic is_rc_clock(input logic [2:0] sel);
		return sel[1:0] == 2'h3;
	endfunction

	// Counter mask for the divided system clock rates
	function automatic logic [5:0] tad_mask(input logic [2:0] sel);
		case (sel)
			3'h1: return 6'h07;
			3'h2: return 6'h1f;
			3'h4: return 6'h03;
			3'h5: return 6'h0f;
			3'h6: return 6'h3f;
			default: return 6'h01;
		endcase
	endfunction

	function automatic logic is_mapped(input logic [9:0] idx);
		case (idx)
			IDX_INT_CTRL, IDX_PERIPH_FLAGS, IDX_RESULT_HIGH, IDX_CONV_CTRL,
			IDX_PERIPH_ENABLES, IDX_RESULT_LOW, IDX_PIN_CLK_SEL: return 1'b1;
			default: return 1'b0;
		endcase
	endfunction
endpackage

// >>> hdl/asr_sar.sv
`timescale 1ns/1ps
module asr_sar (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// Control
	input wire logic start,
	input wire logic abort,
	input wire logic tad_en,
	// Comparator from the analog core
	input wire logic cmp_in,
	// Status and result
	output logic busy,
	output logic done,
	output logic [9:0] dac_code,
	output logic [9:0] result
);
	logic cmp_meta;
	logic cmp_sync;
	logic [3:0] step;
	logic [3:0] next_step;
	logic next_busy;
	logic next_done;
	logic [9:0] next_code;
	logic [9:0] next_result;
	logic [1:0] settle;
	logic [1:0] next_settle;

	// Comparator is asynchronous to us
	always_ff @(posedge ref_clk)
	begin
		cmp_meta <= cmp_in;
		cmp_sync <= cmp_meta;
	end

	// One sample period, then one period per bit, most significant first
	// A new trial code needs three edges to come back through the synchroniser;
	// a bit period that comes sooner is skipped, so the fastest rate runs at half speed
	always_comb
	begin
		next_step = step;
		next_busy = busy;
		next_done = 1'b0;
		next_code = dac_code;
		next_result = result;
		next_settle = (settle == 2'h3) ? settle : settle + 2'h1;
		if (abort)
			next_busy = 1'b0;
		else if (start)
		begin
			next_busy = 1'b1;
			next_step = 4'ha;
			next_code = 10'h200;
			next_settle = 2'h0;
		end
		else if (busy && tad_en && (step == 4'ha || settle[1]))
		begin
			next_step = step - 4'h1;
			if (step != 4'ha)
			begin
				next_settle = 2'h0;
				next_code[step] = cmp_sync;
				if (step != 4'h0)
					next_code[step - 4'h1] = 1'b1;
				else
				begin
					next_busy = 1'b0;
					next_done = 1'b1;
					next_result = next_code;
				end
			end
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			step <= 4'h0;
			settle <= 2'h0;
			busy <= 1'b0;
			done <= 1'b0;
			dac_code <= 10'h000;
			result <= 10'h000;
		end
		else
		begin
			step <= next_step;
			settle <= next_settle;
			busy <= next_busy;
			done <= next_done;
			dac_code <= next_code;
			result <= next_result;
		end
	end
endmodule

// >>> verification/asr_analog_model.sv
`timescale 1ns/1ps
module asr_analog_model (
	// Clock
	input wire logic ref_clk,
	// Conversion core side
	input wire logic conv_power,
	input wire logic [9:0] dac_code,
	input wire logic [9:0] analog_level,
	// Comparator answer
	output logic cmp_out
);
	// ****************************************
	// Comparator of the sampled input
	// ****************************************
	logic scramble = 1'b0;

	// A core without power gives no answer, so the line toggles rather than holding a value
	always_ff @(posedge ref_clk)
	begin
		scramble <= ~scramble;
	end

	// High while the held input is at or above the trial code
	always_comb
	begin
		cmp_out = conv_power ? (analog_level >= dac_code) : scramble;
	end
endmodule

// >>> verification/asr_ctrl_tb.sv
`timescale 1ns/1ps
module asr_ctrl_tb;
	// ****************************************
	// Addresses, signals and instances
	// ****************************************
	localparam logic [11:0] A_INT = {asr_pkg::IDX_INT_CTRL, 2'h0};
	localparam logic [11:0] A_FLAGS = {asr_pkg::IDX_PERIPH_FLAGS, 2'h0};
	localparam logic [11:0] A_HIGH = {asr_pkg::IDX_RESULT_HIGH, 2'h0};
	localparam logic [11:0] A_CTRL = {asr_pkg::IDX_CONV_CTRL, 2'h0};
	localparam logic [11:0] A_ENABLES = {asr_pkg::IDX_PERIPH_ENABLES, 2'h0};
	localparam logic [11:0] A_LOW = {asr_pkg::IDX_RESULT_LOW, 2'h0};
	localparam logic [11:0] A_SEL = {asr_pkg::IDX_PIN_CLK_SEL, 2'h0};
	logic ref_clk;
	logic reset = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic sleep_active = 1'b0;
	logic [9:0] analog_level = 10'h000;
	logic [31:0] prdata;
	logic pready, pslverr, wake_req, irq, conv_power, cmp_in;
	logic [3:0] pins;
	logic [1:0] chan;
	logic vref;
	logic [9:0] dac_code;
	logic [7:0] q;
	logic err;
	int failures = 0;
	int checks = 0;

	// Free-running system clock, 4 ns period
	initial
	begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end

	asr_ctrl dut (.ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.sleep_active(sleep_active), .wake_req(wake_req), .irq(irq), .conv_power(conv_power),
		.channel_select(chan), .reference_select(vref), .analog_pin_select(pins), .dac_code(dac_code),
		.cmp_in(cmp_in));

	asr_analog_model core (.ref_clk(ref_clk), .conv_power(conv_power), .dac_code(dac_code),
		.analog_level(analog_level), .cmp_out(cmp_in));

	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic report_and_stop();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
		checks++;
		if (got !== exp)
		begin
			failures++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic chk_bit(input string what, input logic exp, input logic got);
		checks++;
		if (got !== exp)
		begin
			failures++;
			$display("mismatch %s expected %b seen %b", what, exp, got);
		end
	endtask

	// One APB transfer; request held until pready is seen high, then released, then one idle edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge ref_clk);
		penable <= 1'b1;
		@(posedge ref_clk);
		// Only the watchdog ends a wait for the answer
		while (pready !== 1'b1)
			@(posedge ref_clk);
		q = prdata[7:0];
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge ref_clk);
	endtask

	task automatic do_reset();
		reset <= 1'b1;
		repeat (4) @(posedge ref_clk);
		reset <= 1'b0;
		@(posedge ref_clk);
	endtask

	// Turn on, let the input settle, then set go
	task automatic start_conv(input logic just, input logic [2:0] clk_sel, input logic [9:0] level);
		analog_level <= level;
		apb(1'b1, A_SEL, {1'b0, clk_sel, 4'hf});
		apb(1'b1, A_CTRL, {just, 7'h01});
		repeat (8) @(posedge ref_clk); // acquisition wait
		apb(1'b1, A_CTRL, {just, 7'h03});
	endtask

	// Poll the go bit under a bounded count
	task automatic wait_done();
		int n;
		n = 0;
		q = 8'h02;
		while (q[1] !== 1'b0 && n < 3000)
		begin
			n++;
			apb(1'b0, A_CTRL, 8'h00);
		end
		chk_bit("go cleared", 1'b0, q[1]);
	endtask

	task automatic check_result(input logic just, input logic [9:0] level);
		apb(1'b0, A_HIGH, 8'h00);
		chk_byte("result high", just ? {6'h0, level[9:8]} : level[9:2], q);
		apb(1'b0, A_LOW, 8'h00);
		chk_byte("result low", just ? level[7:0] : {level[1:0], 6'h0}, q);
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_reset_values();
		apb(1'b0, A_INT, 8'hff);
		chk_byte("interrupt control", 8'h00, q);
		apb(1'b0, A_FLAGS, 8'hff);
		chk_byte("flags", 8'h00, q);
		apb(1'b0, A_CTRL, 8'hff);
		chk_byte("converter control", 8'h00, q);
		apb(1'b0, A_ENABLES, 8'hff);
		chk_byte("enables", 8'h00, q);
		apb(1'b0, A_SEL, 8'hff);
		chk_byte("pin and clock select", 8'h0f, q);
		chk_byte("analog pins", 8'h0f, {4'h0, pins});
		apb(1'b0, 12'h004, 8'h00);
		chk_bit("unmapped error", 1'b1, err);
	endtask

	// Left-justified conversion, then the interrupt gated, masked and cleared
	task automatic t_conv_irq();
		apb(1'b1, A_INT, 8'hc0);
		apb(1'b1, A_ENABLES, 8'h40);
		start_conv(1'b0, 3'h0, 10'h2b5);
		wait_done();
		check_result(1'b0, 10'h2b5);
		apb(1'b0, A_FLAGS, 8'h00);
		chk_byte("flag set", 8'h40, q);
		chk_bit("irq enabled", 1'b1, irq);
		apb(1'b1, A_INT, 8'h40);
		chk_bit("irq without global", 1'b0, irq);
		apb(1'b1, A_INT, 8'hc0);
		chk_bit("irq restored", 1'b1, irq);
		apb(1'b1, A_FLAGS, 8'h40);
		apb(1'b0, A_FLAGS, 8'h00);
		chk_byte("flag cleared", 8'h00, q);
		chk_bit("irq after clear", 1'b0, irq);
	endtask

	// Sleep with a divided clock aborts; the on bit stays set and results keep their value
	task automatic t_sleep_abort();
		apb(1'b1, A_FLAGS, 8'h40); // Clear the flag left by the previous conversion
		start_conv(1'b0, 3'h2, 10'h0aa);
		sleep_active <= 1'b1;
		repeat (3) @(posedge ref_clk);
		chk_bit("power in sleep", 1'b0, conv_power);
		apb(1'b0, A_CTRL, 8'h00);
		chk_byte("control after abort", 8'h01, q);
		apb(1'b0, A_FLAGS, 8'h00);
		chk_byte("no flag after abort", 8'h00, q);
		check_result(1'b1, 10'h1c3);
		sleep_active <= 1'b0;
		repeat (2) @(posedge ref_clk);
		chk_bit("power after sleep", 1'b1, conv_power);
	endtask

	// RC clock: conversion runs through sleep and wakes the device
	task automatic t_rc_wake();
		int n;
		logic seen;
		n = 0;
		seen = 1'b0;
		apb(1'b1, A_INT, 8'h40);
		start_conv(1'b0, 3'h3, 10'h0ff);
		sleep_active <= 1'b1;
		while (!seen && n < 7000)
		begin
			n++;
			@(posedge ref_clk);
			seen = (wake_req === 1'b1);
		end
		chk_bit("wake pulse", 1'b1, seen);
		sleep_active <= 1'b0;
		@(posedge ref_clk);
		check_result(1'b0, 10'h0ff);
		apb(1'b1, A_FLAGS, 8'h40);
	endtask

	// RC clock without the converter enable: powers down, on bit stays
	task automatic t_rc_nowake();
		apb(1'b1, A_ENABLES, 8'h00);
		start_conv(1'b1, 3'h7, 10'h300);
		sleep_active <= 1'b1;
		wait_done();
		chk_bit("power after completion", 1'b0, conv_power);
		chk_byte("control after completion", 8'h81, q);
		check_result(1'b1, 10'h300);
		sleep_active <= 1'b0;
		@(posedge ref_clk);
	endtask

	// Reset in mid-conversion: controls return, results stay
	task automatic t_reset_mid();
		start_conv(1'b0, 3'h0, 10'h155);
		repeat (6) @(posedge ref_clk);
		do_reset();
		chk_bit("power after reset", 1'b0, conv_power);
		apb(1'b0, A_CTRL, 8'h00);
		chk_byte("control after reset", 8'h00, q);
		apb(1'b0, A_FLAGS, 8'h00);
		chk_byte("flags after reset", 8'h00, q);
		apb(1'b0, A_SEL, 8'h00);
		chk_byte("select after reset", 8'h0f, q);
		chk_byte("channel and reference after reset", 8'h00, {5'h0, vref, chan});
		check_result(1'b1, 10'h300);
		apb(1'b1, A_CTRL, 8'h4c);
		chk_byte("channel and reference", 8'h07, {5'h0, vref, chan});
	endtask

	// ****************************************
	// Main sequence and watchdog
	// ****************************************
	initial
	begin
		do_reset();
		t_reset_values();
		t_conv_irq();
		start_conv(1'b1, 3'h4, 10'h1c3);
		wait_done();
		check_result(1'b1, 10'h1c3);
		t_sleep_abort();
		t_rc_wake();
		t_rc_nowake();
		t_reset_mid();
		report_and_stop();
	end

	// Whole run needs about 12000 cycles; five times that means a hang
	initial
	begin
		repeat (60000) @(posedge ref_clk);
		failures++;
		$display("mismatch watchdog expected finish seen timeout");
		report_and_stop();
	end
endmodule
